// ---- verilog/boot_strap_latch.sv ----
// Purpose: Latch strap pin levels at system reset and decode boot settings
// Assumes: One 50 MHz clock; resetn is the power-on / watchdog / brownout reset
// Notes:   Strap capture happens once per resetn release; overrides are firmware's
//
// Our own choices: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/10ps

// Overview of operation
// - Sample strap levels during system reset
// - Hold captured bits until power down
// - One status register shows all five bits
// - Weak pulls enabled on straps during reset
// - Release pins to normal use after reset
// - Supply strap: 0 gives 3.3V, 1 1.8V
// - Boot-select 1 flash; both 0 download
// - Log strap 1 enables boot console log
// - Log and edge straps pick SDIO edges
// - Firmware may override voltage and SDIO edges
// - Module enable active high, low before capture holds reset
module boot_strap_latch
  import strap_pkg::*;
#(
  parameter int unsigned SETTLE_CYCLES = 4
) (
  input  wire logic                  clock,
  input  wire logic                  resetn,
  input  wire logic                  moduleEnable,
  // Strap pins, split into level in, level out and enable
  input  wire logic [STRAP_COUNT-1:0] strapPinIn,
  input  wire logic [STRAP_COUNT-1:0] funcPinOut,
  input  wire logic [STRAP_COUNT-1:0] funcPinOe,
  output logic      [STRAP_COUNT-1:0] strapPinOut,
  output logic      [STRAP_COUNT-1:0] strapPinOe,
  output logic      [STRAP_COUNT-1:0] pullUpEn,
  output logic      [STRAP_COUNT-1:0] pullDownEn,
  // Decoded settings
  output logic                       supply18Select,
  output logic                       bootFromFlash,
  output logic                       bootDownload,
  output logic                       consoleLogEnable,
  output logic                       consoleSerialOutSilent,
  output logic                       sdioInRise,
  output logic                       sdioOutRise,
  output logic                       strapValid,
  // Avalon-MM slave
  input  wire logic [ADDR_WIDTH-1:0] address,
  input  wire logic                  read,
  input  wire logic                  write,
  input  wire logic [31:0]           writedata,
  input  wire logic [3:0]            byteenable,
  output logic      [31:0]           readdata,
  output logic                       waitrequest
);

  // Capture sequencing
  typedef enum logic [1:0] {
    ST_SETTLE,
    ST_CAPTURE,
    ST_RUN
  } cap_state_t;

  logic [STRAP_COUNT-1:0] pinSync;
  logic [STRAP_COUNT-1:0] strap_ff;
  logic [4:0]             override_ff;
  logic [7:0]             settle_ff;
  logic                   enSync1_ff;
  logic                   enSync2_ff;
  logic                   respPending_ff;
  cap_state_t             state_ff;
  cap_state_t             nxt_state;
  boot_cfg_t              cfg;
  logic                   inReset;
  logic                   sysResetn;

  // Capture sequence after resetn release, edge by edge:
  //   edges 1-2   module enable passes its two sync stages
  //   edges 3-6   settle counter runs while pulls charge the pins
  //   edge 7      state moves to capture
  //   edge 8      synchronised pin levels land in strap_ff
  //   edge 9      strapValid and decoded settings appear
  // The enable sync stages cover the pin sync stages as well, so the
  // value taken is the level that stood with the pulls already on.
  // A shorter settle count still cannot take the sync reset value.
  //
  // Enable low before capture parks the block in the settle state.
  // Enable low after capture has no effect: only resetn re-arms it,
  // since the straps must survive until power is removed.
  //
  // Bus timing, one wait state per access:
  //   edge N      request first seen, waitrequest falls
  //   edge N+1    master sees waitrequest low; write lands here,
  //               read data already stands from edge N
  //   edge N+1    waitrequest also rises again here
  // A request still held at N+2 would start a second access, so
  // the master must drop it right after the completing edge.
  //
  // Hazards and limits:
  //   the status word is read-only; writes to it are dropped
  //   the log enable has no override, only voltage and SDIO edges
  //   overrides reach the decoded outputs one edge after landing
  //   the undefined boot code sets neither boot output
  //   unmapped offsets read as zero and ignore writes
  //
  // Trade-off: decoded outputs are flops, which costs one cycle of
  // latency but keeps every pin-facing output glitch free.

  // Module enable crosses in from a pin
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      enSync1_ff <= 1'b0;
      enSync2_ff <= 1'b0;
    end else begin
      enSync1_ff <= moduleEnable;
      enSync2_ff <= enSync1_ff;
    end
  end

  // Low enable before capture keeps the block in its reset phase
  assign sysResetn = enSync2_ff;

  pin_sync #(
    .WIDTH (STRAP_COUNT)
  ) u_pin_sync (
    .clock   (clock),
    .resetn  (resetn),
    .pinIn   (strapPinIn),
    .pinSync (pinSync)
  );

  // Pulls stay on until the capture has been made
  assign inReset = (state_ff != ST_RUN);

  // Next capture state
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_SETTLE:  begin
        if (sysResetn && (settle_ff == 8'(SETTLE_CYCLES))) begin
          nxt_state = ST_CAPTURE;
        end
      end
      ST_CAPTURE: nxt_state = ST_RUN;
      ST_RUN:     nxt_state = ST_RUN;
      default:    nxt_state = ST_SETTLE;
    endcase
  end

  // Capture runs once per resetn release; enable low before capture re-enters reset phase
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_ff <= ST_SETTLE;
    end else if (!sysResetn && state_ff != ST_RUN) begin
      state_ff <= ST_SETTLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Settle counter lets pulls and sync stages charge the pins first
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      settle_ff <= 8'h00;
    end else if (state_ff != ST_SETTLE || !sysResetn) begin
      settle_ff <= 8'h00;
    end else if (settle_ff != 8'(SETTLE_CYCLES)) begin
      settle_ff <= settle_ff + 8'h01;
    end
  end

  // Straps are taken only in the capture state, then held
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      strap_ff <= '0;
    end else if (state_ff == ST_CAPTURE) begin
      strap_ff <= pinSync;
    end
  end
  // Nothing else writes strap_ff, so later pin activity is ignored

  // Pulls active during reset phase, then pins go to their functions
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pullUpEn    <= PULL_UP_MASK;
      pullDownEn  <= ~PULL_UP_MASK;
      strapPinOut <= '0;
      strapPinOe  <= '0;
      strapValid  <= 1'b0;
    end else begin
      pullUpEn    <= inReset ? PULL_UP_MASK : '0;
      pullDownEn  <= inReset ? ~PULL_UP_MASK : '0;
      strapPinOut <= inReset ? '0 : funcPinOut;
      strapPinOe  <= inReset ? '0 : funcPinOe;
      strapValid  <= !inReset;
    end
  end

  // Decode latched straps, with firmware overrides on top
  always_comb begin
    cfg.supply18  = override_ff[POS_OVR_VOLT_EN] ? override_ff[POS_OVR_VOLT]
                                                 : strap_ff[POS_SUPPLY];
    if (strap_ff[POS_BOOTSEL]) begin
      cfg.bootMode = BOOT_FLASH;
    end else if (!strap_ff[POS_QUALIFY]) begin
      cfg.bootMode = BOOT_DOWNLOAD;
    end else begin
      cfg.bootMode = BOOT_UNDEFINED;
    end
    cfg.logEnable = strap_ff[POS_LOGTIME];
    if (override_ff[POS_OVR_EDGE_EN]) begin
      cfg.sdioInRise  = override_ff[POS_OVR_IN_EDGE];
      cfg.sdioOutRise = override_ff[POS_OVR_OUT_EDGE];
    end else begin
      cfg.sdioInRise  = strap_ff[POS_LOGTIME];
      cfg.sdioOutRise = strap_ff[POS_SDIOEDGE];
    end
  end

  // Registered settings outputs; quiet until capture is done
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      supply18Select         <= 1'b0;
      bootFromFlash          <= 1'b0;
      bootDownload           <= 1'b0;
      consoleLogEnable       <= 1'b0;
      consoleSerialOutSilent <= 1'b1;
      sdioInRise             <= 1'b0;
      sdioOutRise            <= 1'b0;
    end else if (!inReset) begin
      supply18Select         <= cfg.supply18;
      bootFromFlash          <= (cfg.bootMode == BOOT_FLASH);
      bootDownload           <= (cfg.bootMode == BOOT_DOWNLOAD);
      consoleLogEnable       <= cfg.logEnable;
      consoleSerialOutSilent <= !cfg.logEnable;
      sdioInRise             <= cfg.sdioInRise;
      sdioOutRise            <= cfg.sdioOutRise;
    end
  end

  // Override register; only the low byte lane carries fields
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      override_ff <= OVERRIDE_RESET;
    end else if (write && !waitrequest && address == OFS_OVERRIDE && byteenable[0]) begin
      override_ff <= writedata[4:0];
    end
  end
  // Writes to the status offset fall through unused

  // One wait state per access: waitrequest drops the cycle after request
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      respPending_ff <= 1'b0;
    end else begin
      respPending_ff <= (read || write) && !respPending_ff;
    end
  end

  // waitrequest is registered so the output stays a flop
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= !((read || write) && !respPending_ff);
    end
  end

  // Read data prepared with the wait-state; unmapped reads give zero
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      readdata <= 32'h0000_0000;
    end else if (read && !respPending_ff) begin
      case (address)
        OFS_STRAP_STATUS: readdata <= {27'h0, strap_ff};
        OFS_OVERRIDE:     readdata <= {27'h0, override_ff};
        OFS_EFFECTIVE:    readdata <= {26'h0, cfg.sdioOutRise, cfg.sdioInRise, cfg.logEnable,
                                       (cfg.bootMode == BOOT_FLASH),
                                       (cfg.bootMode == BOOT_DOWNLOAD), cfg.supply18};
        default:          readdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule

// ---- verilog/strap_pkg.sv ----
// Purpose: Shared constants and types for the boot strap latch
// Assumes: Avalon-MM register slave, 32-bit data, word addresses in bytes
// Notes:   Bit order of the strap word is fixed here and used everywhere
package strap_pkg;

  localparam int unsigned STRAP_COUNT = 5;
  localparam int unsigned ADDR_WIDTH  = 4;

  // Register byte offsets
  localparam logic [3:0] OFS_STRAP_STATUS = 4'h0;
  localparam logic [3:0] OFS_OVERRIDE     = 4'h4;
  localparam logic [3:0] OFS_EFFECTIVE    = 4'h8;

  // Strap word bit positions
  localparam int unsigned POS_SUPPLY   = 0;
  localparam int unsigned POS_BOOTSEL  = 1;
  localparam int unsigned POS_QUALIFY  = 2;
  localparam int unsigned POS_LOGTIME  = 3;
  localparam int unsigned POS_SDIOEDGE = 4;

  // Pull direction while in reset: 1 pulls up, 0 pulls down
  localparam logic [4:0] PULL_UP_MASK  = 5'h1A;

  // Override register fields
  localparam int unsigned POS_OVR_VOLT_EN  = 0;
  localparam int unsigned POS_OVR_VOLT     = 1;
  localparam int unsigned POS_OVR_EDGE_EN  = 2;
  localparam int unsigned POS_OVR_IN_EDGE  = 3;
  localparam int unsigned POS_OVR_OUT_EDGE = 4;
  localparam logic [4:0]  OVERRIDE_RESET   = 5'h00;

  // Effective settings register fields
  localparam int unsigned POS_EFF_VOLT     = 0;
  localparam int unsigned POS_EFF_DOWNLOAD = 1;
  localparam int unsigned POS_EFF_FLASH    = 2;
  localparam int unsigned POS_EFF_LOG      = 3;
  localparam int unsigned POS_EFF_IN_EDGE  = 4;
  localparam int unsigned POS_EFF_OUT_EDGE = 5;

  // Boot source decoded from straps
  typedef enum logic [1:0] {
    BOOT_FLASH,
    BOOT_DOWNLOAD,
    BOOT_UNDEFINED
  } boot_mode_t;

  // Settings decoded from the straps (and overrides)
  typedef struct packed {
    logic       supply18;
    boot_mode_t bootMode;
    logic       logEnable;
    logic       sdioInRise;
    logic       sdioOutRise;
  } boot_cfg_t;

endpackage

// ---- verilog/pin_sync.sv ----
// Purpose: Two-flop synchroniser for a group of pin levels
// Assumes: Pins are asynchronous to clock
// Notes:   First stage is read only by the second stage
`timescale 1ns/10ps
module pin_sync #(
  parameter int unsigned WIDTH = 5
) (
  input  wire logic             clock,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] pinSync
);

  logic [WIDTH-1:0] stage1_ff;

  // Plain double flop, reset to zero
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      stage1_ff <= '0;
      pinSync   <= '0;
    end else begin
      stage1_ff <= pinIn;
      pinSync   <= stage1_ff;
    end
  end

endmodule

// ---- testbench/strap_pins_model.sv ----
// Purpose: Board side of the strap pins: resistors or host outputs
// Assumes: One pin per strap bit, weak pulls come from the latch
// Notes:   A floating pin with no pull toggles, so nothing passes by luck
`timescale 1ns/10ps
module strap_pins_model (
  input  wire logic       clock,
  input  wire logic [4:0] level,
  input  wire logic [4:0] drive,
  input  wire logic [4:0] pinOut,
  input  wire logic [4:0] pinOe,
  input  wire logic [4:0] pullUpEn,
  input  wire logic [4:0] pullDownEn,
  output logic      [4:0] pinLevel
);
  logic [4:0] noise_ff = 5'h15;

  // Undriven and unpulled pins wander every cycle
  always_ff @(posedge clock) begin
    noise_ff <= ~noise_ff;
  end

  // Latch drive wins, then the board, then the weak pulls
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      pinLevel[i] = pinOe[i] ? pinOut[i] : drive[i] ? level[i] :
                    pullUpEn[i] ? 1'b1 : pullDownEn[i] ? 1'b0 : noise_ff[i];
    end
  end
endmodule

// ---- testbench/boot_strap_latch_asserts.sv ----
// Purpose: Port-level checks of the strap latch
// Assumes: Single clock domain, resetn active low
// Notes:   Attached by bind below
`timescale 1ns/10ps
module boot_strap_latch_asserts (
  input wire logic       clock,
  input wire logic       resetn,
  input wire logic       moduleEnable,
  input wire logic [4:0] funcPinOut,
  input wire logic [4:0] funcPinOe,
  input wire logic [4:0] strapPinOut,
  input wire logic [4:0] strapPinOe,
  input wire logic [4:0] pullUpEn,
  input wire logic [4:0] pullDownEn,
  input wire logic       bootFromFlash,
  input wire logic       bootDownload,
  input wire logic       consoleLogEnable,
  input wire logic       consoleSerialOutSilent,
  input wire logic       strapValid,
  input wire logic       read,
  input wire logic       write,
  input wire logic       waitrequest
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  property p_pullsOn; pullUpEn != 5'h00 |-> pullUpEn == 5'h1A && pullDownEn == 5'h05 && strapPinOe == 5'h00; endproperty
  a_pullsOn: assert property (p_pullsOn) else $error("pulls wrong in capture");
  property p_pullsOff; strapValid |-> pullUpEn == 5'h00 && pullDownEn == 5'h00; endproperty
  a_pullsOff: assert property (p_pullsOff) else $error("pulls left on");
  property p_passThru;
    strapValid && $past(strapValid) |-> strapPinOe == $past(funcPinOe) && strapPinOut == $past(funcPinOut);
  endproperty
  a_passThru: assert property (p_passThru) else $error("pins not released");
  property p_hold; strapValid && $past(strapValid) |-> $stable({bootFromFlash, bootDownload, consoleLogEnable}); endproperty
  a_hold: assert property (p_hold) else $error("latched setting moved");
  property p_bootExcl; strapValid |-> !(bootFromFlash && bootDownload); endproperty
  a_bootExcl: assert property (p_bootExcl) else $error("two boot sources");
  property p_logPair; strapValid |-> consoleLogEnable != consoleSerialOutSilent; endproperty
  a_logPair: assert property (p_logPair) else $error("log and silent agree");
  property p_enableHold; !moduleEnable [*6] |-> !$rose(strapValid); endproperty
  a_enableHold: assert property (p_enableHold) else $error("capture while disabled");
  property p_waitAns; $rose(read || write) |=> !waitrequest; endproperty
  a_waitAns: assert property (p_waitAns) else $error("bus answer late");
  property p_waitOne; !waitrequest |=> waitrequest; endproperty
  a_waitOne: assert property (p_waitOne) else $error("waitrequest low too long");

  // Main scenarios reached
  c_capture: cover property ($rose(strapValid));
  c_read: cover property (read && !waitrequest);
  c_write: cover property (write && !waitrequest);
endmodule

bind boot_strap_latch boot_strap_latch_asserts i_chk (.clock, .resetn, .moduleEnable, .funcPinOut, .funcPinOe,
  .strapPinOut, .strapPinOe, .pullUpEn, .pullDownEn, .bootFromFlash, .bootDownload, .consoleLogEnable,
  .consoleSerialOutSilent, .strapValid, .read, .write, .waitrequest);

// ---- testbench/test_boot_strap_latch.sv ----
// Purpose: Self-checking bench for the strap latch
// Assumes: Bus answers within a bounded count
// Notes:   One reset per table row, since capture happens once per reset
`timescale 1ns/10ps
module test_boot_strap_latch;
  import strap_pkg::*;
  typedef struct packed { logic [4:0] s; logic [4:0] d; logic [5:0] e; } row_t;
  logic clock = 1'b0, resetn = 1'b0, moduleEnable = 1'b0, read = 1'b0, write = 1'b0;
  logic [4:0] lvl = 5'h00, drv = 5'h00, funcPinOut = 5'h00, funcPinOe = 5'h00;
  logic [4:0] pinLevel, strapPinOut, strapPinOe, pullUpEn, pullDownEn, st;
  logic [3:0] address = 4'h0, byteenable = 4'hF;
  logic [31:0] writedata = 32'h0, readdata, rd;
  logic supply18Select, bootFromFlash, bootDownload, consoleLogEnable, consoleSerialOutSilent;
  logic sdioInRise, sdioOutRise, strapValid, waitrequest;
  int failures = 0, comparisons = 0;
  // e = {1.8V, flash, download, log, in-rise, out-rise}; last row sets download only
  row_t rows [6] = '{'{5'h1F, 5'h1F, 6'h37}, '{5'h12, 5'h1F, 6'h11}, '{5'h0D, 5'h1F, 6'h26},
                     '{5'h00, 5'h00, 6'h17}, '{5'h01, 5'h03, 6'h2F}, '{5'h00, 5'h1F, 6'h08}};

  always #10 clock = ~clock;

  strap_pins_model i_pins (.clock, .level(lvl), .drive(drv), .pinOut(strapPinOut), .pinOe(strapPinOe),
    .pullUpEn, .pullDownEn, .pinLevel);
  boot_strap_latch i_dut (.clock, .resetn, .moduleEnable, .strapPinIn(pinLevel), .funcPinOut, .funcPinOe,
    .strapPinOut, .strapPinOe, .pullUpEn, .pullDownEn, .supply18Select, .bootFromFlash, .bootDownload,
    .consoleLogEnable, .consoleSerialOutSilent, .sdioInRise, .sdioOutRise, .strapValid, .address, .read,
    .write, .writedata, .byteenable, .readdata, .waitrequest);

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One bus access, held until waitrequest is sampled low
  task automatic bus(input logic we, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    address <= a;
    writedata <= wd;
    read <= !we;
    write <= we;
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (waitrequest !== 1'b0) begin
      failures++;
      wrap_up();
    end
    d = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  // Pulse reset, then wait a bounded time for capture
  task automatic do_reset(input logic en);
    int n;
    n = 0;
    moduleEnable <= en;
    resetn <= 1'b0;
    repeat (10) @(posedge clock);
    resetn <= 1'b1;
    while (strapValid !== 1'b1 && n < 100) begin
      @(posedge clock);
      n++;
    end
    repeat (2) @(posedge clock);
  endtask

  task automatic wrap_up;
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    wrap_up();
  end

  initial begin
    foreach (rows[i]) begin
      lvl <= rows[i].s;
      drv <= rows[i].d;
      funcPinOe <= 5'h00;
      do_reset(1'b1);
      st = (rows[i].s & rows[i].d) | (PULL_UP_MASK & ~rows[i].d);
      chk(strapValid, 1);
      chk({supply18Select, bootFromFlash, bootDownload, consoleLogEnable, sdioInRise, sdioOutRise}, rows[i].e);
      chk(consoleSerialOutSilent, !rows[i].e[2]);
      bus(0, OFS_STRAP_STATUS, 0, rd);
      chk(rd, {27'h0, st});
      bus(0, OFS_EFFECTIVE, 0, rd);
      chk(rd, {26'h0, rows[i].e[0], rows[i].e[1], rows[i].e[2], rows[i].e[4], rows[i].e[3], rows[i].e[5]});
      // Disturb pins and enable after capture; status must not move
      lvl <= ~rows[i].s;
      drv <= 5'h1F;
      moduleEnable <= 1'b0;
      funcPinOe <= 5'h03;
      funcPinOut <= 5'h01;
      bus(1, OFS_STRAP_STATUS, 32'hFFFFFFFF, rd);
      repeat (5) @(posedge clock);
      bus(0, OFS_STRAP_STATUS, 0, rd);
      chk(rd, {27'h0, st});
    end
    // Overrides need their enable bits
    bus(1, OFS_OVERRIDE, 32'h1F, rd);
    repeat (3) @(posedge clock);
    chk({supply18Select, sdioInRise, sdioOutRise}, 3'h7);
    // Write with the low lane disabled must leave the overrides alone
    byteenable <= 4'h0;
    bus(1, OFS_OVERRIDE, 32'h00, rd);
    byteenable <= 4'hF;
    bus(0, OFS_OVERRIDE, 0, rd);
    chk(rd, 32'h1F);
    bus(1, OFS_OVERRIDE, 32'h0A, rd);
    repeat (3) @(posedge clock);
    chk({supply18Select, sdioInRise, sdioOutRise}, 3'h0);
    bus(0, OFS_OVERRIDE, 0, rd);
    chk(rd, 32'h0A);
    bus(0, OFS_STRAP_STATUS, 0, rd);
    chk(rd, {27'h0, st});
    bus(0, 4'hC, 0, rd);
    chk(rd, 32'h0);
    // Enable low holds the block before capture
    drv <= 5'h00;
    funcPinOe <= 5'h00;
    do_reset(1'b0);
    chk(strapValid, 0);
    chk({pullUpEn, pullDownEn}, {5'h1A, 5'h05});
    moduleEnable <= 1'b1;
    repeat (40) @(posedge clock);
    chk(strapValid, 1);
    bus(0, OFS_STRAP_STATUS, 0, rd);
    chk(rd, {27'h0, PULL_UP_MASK});
    wrap_up();
  end
endmodule
